/* core/tsr_regs.sv */
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// temperature read-back and trip limit registers behind an AXI4-Lite slave
//
// Behaviour
// - temperatures and limits are 13-bit two's complement with 0.0625 C per bit.
// - read-back temperature has 0.125 C resolution and bit 0 always reads zero.
// - bit 11 weighs 128 C and bit 12 is the sign.
// - the top three read-back bits are trip status from the current sample, not the event pin.
// - negatives are sign plus two's complement, so -0.125 C reads 1FFEh or FFFEh with status set.
// - the upper limit is writable in bits 12:2, two's complement, 0.25 C per step.
// - the lower limit is writable in bits 12:2, two's complement, 0.25 C per step.
// - the critical limit is writable in bits 12:2, two's complement, 0.25 C per step.
// - bits 15:13 and 1:0 of each limit register are read-only zero.
// - comparisons use the limits as currently programmed, with no commit step.
// - read-back bit 13 is below-window, bit 14 above-window, bit 15 above-critical.
`include "tsr_defines.svh"
module tsr_regs
    import tsr_pkg::*;
#(
    parameter int ADDR_W = `TSR_AXI_ADDR_W
)
(
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic [12:0]       TEMP_SAMPLE,
    input  wire logic              TEMP_VALID,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    output logic                   IRQ
);
    logic [15:0]       upper_limit_field_q;
    logic [15:0]       lower_limit_field_q;
    logic [15:0]       critical_limit_field_q;
    logic [12:0]       temp_q;
    tsr_trip_t         trip_d;
    tsr_trip_t         trip_q;
    logic [2:0]        status_q;
    logic [2:0]        mask_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_have_q;
    logic              w_have_q;
    tsr_wstate_t       wstate_q;
    logic              do_write;
    logic              rd_take;
    logic              rd_status;
    logic [15:0]       temp_word;
    logic [15:0]       wmerge;
    logic [15:0]       wnew;

    // status fields ride on top of the sample
    assign temp_word = {trip_q.crit, trip_q.above, trip_q.below, temp_q};

    // live compare against the present limits, no shadow copies
    tsr_compare u_cmp (
        .sample      (TEMP_SAMPLE & `TSR_TEMP_MASK),
        .upper_limit (upper_limit_field_q),
        .lower_limit (lower_limit_field_q),
        .crit_limit  (critical_limit_field_q),
        .trip        (trip_d)
    );

    // sample capture; bit 0 forced low keeps 0.125 C resolution
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            temp_q <= 13'h0000;
            trip_q <= '0;
        end else if (TEMP_VALID) begin
            temp_q <= TEMP_SAMPLE & `TSR_TEMP_MASK;
            trip_q <= trip_d;
        end
    end

    // write channel: address and data taken in either order
    assign do_write = aw_have_q && w_have_q && (wstate_q == TSR_W_IDLE);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_have_q && !(S_AXI_AWVALID && S_AXI_AWREADY);
            S_AXI_WREADY  <= !w_have_q && !(S_AXI_WVALID && S_AXI_WREADY);
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_q <= 1'b1;
                wdata_q  <= S_AXI_WDATA;
                wstrb_q  <= S_AXI_WSTRB;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                aw_have_q     <= 1'b0;
                w_have_q      <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wstate_q     <= TSR_W_IDLE;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `TSR_RESP_OKAY;
        end else begin
            case (wstate_q)
                TSR_W_IDLE: begin
                    if (do_write) begin
                        wstate_q     <= TSR_W_RESP;
                        S_AXI_BVALID <= 1'b1;
                        case (awaddr_q[7:0])
                            `TSR_OFF_TEMP, `TSR_OFF_UPPER, `TSR_OFF_LOWER, `TSR_OFF_CRIT,
                            `TSR_OFF_STATUS, `TSR_OFF_MASK: S_AXI_BRESP <= `TSR_RESP_OKAY;
                            default: S_AXI_BRESP <= `TSR_RESP_SLVERR;
                        endcase
                    end
                end
                TSR_W_RESP: begin
                    if (S_AXI_BREADY) begin
                        wstate_q     <= TSR_W_IDLE;
                        S_AXI_BVALID <= 1'b0;
                    end
                end
                default: begin
                    wstate_q     <= TSR_W_IDLE;
                    S_AXI_BVALID <= 1'b0;
                end
            endcase
        end
    end

    // byte-lane merge, reserved positions masked away
    always_comb begin
        wmerge = 16'h0000;
        wnew   = 16'h0000;
        case (awaddr_q[7:0])
            `TSR_OFF_UPPER: wmerge = upper_limit_field_q;
            `TSR_OFF_LOWER: wmerge = lower_limit_field_q;
            `TSR_OFF_CRIT:  wmerge = critical_limit_field_q;
            default:        wmerge = 16'h0000;
        endcase
        wnew[7:0]  = wstrb_q[0] ? wdata_q[7:0] : wmerge[7:0];
        wnew[15:8] = wstrb_q[1] ? wdata_q[15:8] : wmerge[15:8];
        wnew       = wnew & `TSR_LIMIT_MASK;
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            upper_limit_field_q    <= `TSR_RST_LIMIT;
            lower_limit_field_q    <= `TSR_RST_LIMIT;
            critical_limit_field_q <= `TSR_RST_LIMIT;
        end else if (do_write) begin
            if (awaddr_q[7:0] == `TSR_OFF_UPPER)
                upper_limit_field_q <= wnew;
            if (awaddr_q[7:0] == `TSR_OFF_LOWER)
                lower_limit_field_q <= wnew;
            if (awaddr_q[7:0] == `TSR_OFF_CRIT)
                critical_limit_field_q <= wnew;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N)
            mask_q <= 3'h0;
        else if (do_write && awaddr_q[7:0] == `TSR_OFF_MASK && wstrb_q[0])
            mask_q <= wdata_q[2:0];
    end

    // read channel
    assign rd_take   = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_status = rd_take && (S_AXI_ARADDR[7:0] == `TSR_OFF_STATUS);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= `TSR_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !rd_take;
            if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID  <= 1'b0;
                S_AXI_ARREADY <= 1'b1;
            end
            if (rd_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= `TSR_RESP_OKAY;
                case (S_AXI_ARADDR[7:0])
                    `TSR_OFF_TEMP:   S_AXI_RDATA <= {16'h0000, temp_word};
                    `TSR_OFF_UPPER:  S_AXI_RDATA <= {16'h0000, upper_limit_field_q};
                    `TSR_OFF_LOWER:  S_AXI_RDATA <= {16'h0000, lower_limit_field_q};
                    `TSR_OFF_CRIT:   S_AXI_RDATA <= {16'h0000, critical_limit_field_q};
                    `TSR_OFF_STATUS: S_AXI_RDATA <= {29'h00000000, status_q};
                    `TSR_OFF_MASK:   S_AXI_RDATA <= {29'h00000000, mask_q};
                    default: begin
                        S_AXI_RDATA <= 32'h00000000;
                        S_AXI_RRESP <= `TSR_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // sticky trip entry events; a new event beats the read clear
    logic [2:0] new_evt;
    assign new_evt = TEMP_VALID ? ({trip_d.crit, trip_d.above, trip_d.below}
                                   & ~{trip_q.crit, trip_q.above, trip_q.below}) : 3'h0;

    always_ff @(posedge CLK) begin
        if (!RESET_N)
            status_q <= 3'h0;
        else
            status_q <= (rd_status ? 3'h0 : status_q) | new_evt;
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N)
            IRQ <= 1'b0;
        else
            IRQ <= |(((rd_status ? 3'h0 : status_q) | new_evt) & mask_q);
    end

    // trip flags are judged against the limits held at the capture edge, not after it
    sequence s_over_crit;
        TEMP_VALID && ($signed(TEMP_SAMPLE & `TSR_TEMP_MASK) > $signed(critical_limit_field_q[12:0]));
    endsequence

    sequence s_over_upper;
        TEMP_VALID && ($signed(TEMP_SAMPLE & `TSR_TEMP_MASK) > $signed(upper_limit_field_q[12:0]));
    endsequence

    sequence s_under_lower;
        TEMP_VALID && ($signed(TEMP_SAMPLE & `TSR_TEMP_MASK) < $signed(lower_limit_field_q[12:0]));
    endsequence

    sequence s_inside_limits;
        TEMP_VALID
        && !($signed(TEMP_SAMPLE & `TSR_TEMP_MASK) > $signed(upper_limit_field_q[12:0]))
        && !($signed(TEMP_SAMPLE & `TSR_TEMP_MASK) < $signed(lower_limit_field_q[12:0]))
        && !($signed(TEMP_SAMPLE & `TSR_TEMP_MASK) > $signed(critical_limit_field_q[12:0]));
    endsequence

    sequence s_upper_write;
        do_write && awaddr_q[7:0] == `TSR_OFF_UPPER && wstrb_q == 4'hF;
    endsequence

    sequence s_lower_write;
        do_write && awaddr_q[7:0] == `TSR_OFF_LOWER && wstrb_q == 4'hF;
    endsequence

    sequence s_crit_write;
        do_write && awaddr_q[7:0] == `TSR_OFF_CRIT && wstrb_q == 4'hF;
    endsequence

    chk_limit_reserved_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        ((upper_limit_field_q | lower_limit_field_q | critical_limit_field_q) & ~`TSR_LIMIT_MASK) == 16'h0000)
        else $error("reserved limit bits set");

    chk_temp_bit0_zero: assert property (@(posedge CLK) disable iff (!RESET_N) temp_q[0] == 1'b0)
        else $error("temperature bit 0 not zero");

    chk_status_tracks_sample: assert property (@(posedge CLK) disable iff (!RESET_N)
        TEMP_VALID |=> (trip_q == $past(trip_d))
                       && (temp_word[12:0] == ($past(TEMP_SAMPLE) & `TSR_TEMP_MASK)))
        else $error("read-back not from last sample");

    chk_crit_above_compare: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_over_crit |=> temp_word[`TSR_BIT_CRIT])
        else $error("over critical flag missing");

    chk_above_window: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_over_upper |=> temp_word[`TSR_BIT_ABOVE])
        else $error("above window flag missing");

    chk_below_window: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_under_lower |=> temp_word[`TSR_BIT_BELOW])
        else $error("below window flag missing");

    chk_no_false_trip: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_inside_limits |=> temp_word[`TSR_BIT_CRIT:`TSR_BIT_BELOW] == 3'h0)
        else $error("trip flag set inside limits");

    chk_upper_write_lands: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_upper_write |=> upper_limit_field_q == ($past(wdata_q[15:0]) & `TSR_LIMIT_MASK))
        else $error("upper limit write lost");

    chk_lower_write_lands: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_lower_write |=> lower_limit_field_q == ($past(wdata_q[15:0]) & `TSR_LIMIT_MASK))
        else $error("lower limit write lost");

    chk_crit_write_lands: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_crit_write |=> critical_limit_field_q == ($past(wdata_q[15:0]) & `TSR_LIMIT_MASK))
        else $error("critical limit write lost");

    chk_reset_clears_limits: assert property (@(posedge CLK)
        !RESET_N |=> (upper_limit_field_q | lower_limit_field_q | critical_limit_field_q) == 16'h0000)
        else $error("limits not cleared by reset");

    chk_limits_need_write: assert property (@(posedge CLK) disable iff (!RESET_N)
        !do_write |=> $stable(upper_limit_field_q)
                      && $stable(lower_limit_field_q)
                      && $stable(critical_limit_field_q))
        else $error("limit changed without a write");

    chk_write_answer: assert property (@(posedge CLK) disable iff (!RESET_N)
        do_write |=> S_AXI_BVALID)
        else $error("write response missing");

    chk_read_answer: assert property (@(posedge CLK) disable iff (!RESET_N)
        rd_take |=> S_AXI_RVALID)
        else $error("read data missing");

    chk_no_read_overlap: assert property (@(posedge CLK) disable iff (!RESET_N)
        S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken while data pending");

    chk_read_upper_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    chk_status_sticky: assert property (@(posedge CLK) disable iff (!RESET_N)
        !rd_status |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("status bit lost without a read");

    chk_status_read_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
        rd_status && !TEMP_VALID |=> status_q == 3'h0)
        else $error("status not cleared by read");

    chk_irq_from_status: assert property (@(posedge CLK) disable iff (!RESET_N)
        IRQ == |(status_q & $past(mask_q)))
        else $error("interrupt does not follow masked status");
endmodule

/* core/tsr_defines.svh */
// offsets, field positions and reset values of the trip register bank
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
`define TSR_OFF_TEMP      8'h00
`define TSR_OFF_UPPER     8'h04
`define TSR_OFF_LOWER     8'h08
`define TSR_OFF_CRIT      8'h0C
`define TSR_OFF_STATUS    8'h10
`define TSR_OFF_MASK      8'h14
`define TSR_LIMIT_MASK    16'h1FFC
`define TSR_TEMP_MASK     13'h1FFE
`define TSR_RST_LIMIT     16'h0000
`define TSR_BIT_BELOW     13
`define TSR_BIT_ABOVE     14
`define TSR_BIT_CRIT      15
`define TSR_RESP_OKAY     2'h0
`define TSR_RESP_SLVERR   2'h2
`define TSR_AXI_ADDR_W    8
`endif

/* core/tsr_pkg.sv */
// types shared by the trip register bank
package tsr_pkg;
    typedef struct packed {
        logic below;
        logic above;
        logic crit;
    } tsr_trip_t;

    typedef enum logic [1:0] {
        TSR_W_IDLE = 2'b00,
        TSR_W_RESP = 2'b01
    } tsr_wstate_t;
endpackage

/* core/tsr_compare.sv */
`timescale 1ns/1ps
// compares one 13-bit temperature sample against the three limits
`include "tsr_defines.svh"
module tsr_compare
    import tsr_pkg::*;
(
    input  wire logic [12:0] sample,
    input  wire logic [15:0] upper_limit,
    input  wire logic [15:0] lower_limit,
    input  wire logic [15:0] crit_limit,
    output tsr_trip_t        trip
);
    // limits carry bit 2 = 0.25 C, sample bit 1 = 0.125 C: both use bit 0 = 0.0625 C
    logic signed [12:0] s_t;
    logic signed [12:0] s_u;
    logic signed [12:0] s_l;
    logic signed [12:0] s_c;

    always_comb begin
        s_t = $signed(sample);
        s_u = $signed(upper_limit[12:0]);
        s_l = $signed(lower_limit[12:0]);
        s_c = $signed(crit_limit[12:0]);
        trip.below = (s_t < s_l);
        trip.above = (s_t > s_u);
        trip.crit  = (s_t > s_c);
    end
endmodule

/* test/tsr_host_model.sv */
`timescale 1ns/1ps
// host model: AXI4-Lite master that reaches the trip register bank
`include "tsr_defines.svh"
module tsr_host_model (
    input  wire logic        clk,
    output logic [7:0]       aw_addr,
    output logic             aw_valid,
    input  wire logic        aw_ready,
    output logic [31:0]      w_data,
    output logic [3:0]       w_strb,
    output logic             w_valid,
    input  wire logic        w_ready,
    input  wire logic [1:0]  b_resp,
    input  wire logic        b_valid,
    output logic             b_ready,
    output logic [7:0]       ar_addr,
    output logic             ar_valid,
    input  wire logic        ar_ready,
    input  wire logic [31:0] r_data,
    input  wire logic [1:0]  r_resp,
    input  wire logic        r_valid,
    output logic             r_ready
);
    // responses are always accepted, so ready stays high for the whole run
    initial begin
        {aw_addr, aw_valid, w_data, w_strb, w_valid, ar_addr, ar_valid} = '0;
        b_ready = 1'b1;
        r_ready = 1'b1;
    end

    task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r, output logic ok);
        ok = 1'b0;
        r = 2'h3;
        @(posedge clk);
        aw_addr <= a;
        aw_valid <= 1'b1;
        w_data <= d;
        w_strb <= s;
        w_valid <= 1'b1;
        for (int n = 0; n < 64 && !ok; n++) begin
            @(posedge clk);
            // released payload is scrambled so a late sample cannot pass
            if (aw_valid && aw_ready) begin
                aw_valid <= 1'b0;
                aw_addr <= ~a;
            end
            if (w_valid && w_ready) begin
                w_valid <= 1'b0;
                w_data <= ~d;
            end
            if (b_valid) begin
                r = b_resp;
                ok = 1'b1;
            end
        end
    endtask

    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output logic ok);
        ok = 1'b0;
        d = '1;
        r = 2'h3;
        @(posedge clk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        for (int n = 0; n < 64 && !ok; n++) begin
            @(posedge clk);
            if (ar_valid && ar_ready) begin
                ar_valid <= 1'b0;
                ar_addr <= ~a;
            end
            if (r_valid) begin
                d = r_data;
                r = r_resp;
                ok = 1'b1;
            end
        end
    endtask
endmodule

/* test/test_temp_format_trip_registers.sv */
`timescale 1ns/1ps
// self-checking bench for the trip register bank
`include "tsr_defines.svh"
module test_temp_format_trip_registers;
    logic        clk, rst_n, t_valid, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic        ar_valid, ar_ready, r_valid, r_ready, irq;
    logic [12:0] t_sample;
    logic [7:0]  aw_addr, ar_addr;
    logic [31:0] w_data, r_data;
    logic [3:0]  w_strb;
    logic [1:0]  b_resp, r_resp;
    int          miscompares = 0;
    int          checks_done = 0;
    // sample in 28:16, expected read-back in 15:0
    localparam logic [31:0] TAB [7] = '{32'h0190_0190, 32'h0193_4192, 32'h07D0_C7D0, 32'h0800_C800,
                                       32'h1FFE_1FFE, 32'h1E70_3E70, 32'h1000_3000};

    tsr_regs i_dut (
        .CLK(clk), .RESET_N(rst_n), .TEMP_SAMPLE(t_sample), .TEMP_VALID(t_valid),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
        .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
        .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready),
        .IRQ(irq)
    );

    tsr_host_model i_host (
        .clk(clk), .aw_addr(aw_addr), .aw_valid(aw_valid), .aw_ready(aw_ready), .w_data(w_data),
        .w_strb(w_strb), .w_valid(w_valid), .w_ready(w_ready), .b_resp(b_resp), .b_valid(b_valid),
        .b_ready(b_ready), .ar_addr(ar_addr), .ar_valid(ar_valid), .ar_ready(ar_ready),
        .r_data(r_data), .r_resp(r_resp), .r_valid(r_valid), .r_ready(r_ready)
    );

    task automatic complete_run();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a bus access that never answers ends the run at once
    task automatic bus_ok(input logic ok);
        if (!ok) begin
            miscompares++;
            $display("MISMATCH t=%0t bus access timed out", $time);
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `TSR_RESP_OKAY,
                      input logic [3:0] s = 4'hF);
        logic [1:0] r;
        logic       ok;
        i_host.write(a, d, s, r, ok);
        bus_ok(ok);
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `TSR_RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        logic        ok;
        i_host.read(a, d, r, ok);
        bus_ok(ok);
        check(d, e);
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic smp(input logic [12:0] s);
        @(posedge clk);
        t_sample <= s;
        t_valid <= 1'b1;
        @(posedge clk);
        t_valid <= 1'b0;
        t_sample <= ~s;
        @(posedge clk);
    endtask

    task automatic irq_is(input logic e);
        for (int n = 0; n < 8 && irq !== e; n++) @(posedge clk);
        check({31'h0, irq}, {31'h0, e});
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        t_valid = 1'b0;
        t_sample = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
        for (int i = 1; i < 4; i++) begin
            wr(8'(4 * i), 32'hFFFF_FFFF);
            rd(8'(4 * i), 32'h0000_1FFC);
        end
        wr(8'h18, 32'h1, `TSR_RESP_SLVERR);
        rd(8'h18, 32'h0, `TSR_RESP_SLVERR);
        wr(`TSR_OFF_MASK, 32'h0);
        wr(`TSR_OFF_UPPER, 32'h0190);
        wr(`TSR_OFF_LOWER, 32'h1FF0);
        wr(`TSR_OFF_CRIT, 32'h07C0);
        for (int i = 0; i < 7; i++) begin
            smp(TAB[i][28:16]);
            rd(`TSR_OFF_TEMP, {16'h0, TAB[i][15:0]});
        end
        irq_is(1'b0);
        rd(`TSR_OFF_STATUS, 32'h7);
        rd(`TSR_OFF_STATUS, 32'h0);
        // only lane 0 strobed: the high byte of the limit keeps its value
        wr(`TSR_OFF_UPPER, 32'hFFFF_00FF, `TSR_RESP_OKAY, 4'h1);
        rd(`TSR_OFF_UPPER, 32'h0000_01FC);
        // read-back word ignores host writes
        wr(`TSR_OFF_TEMP, 32'h0000_FFFF);
        rd(`TSR_OFF_TEMP, 32'h0000_3000);
        // crossed limits put all three trip flags up at once
        wr(`TSR_OFF_UPPER, 32'h1FF8);
        wr(`TSR_OFF_CRIT, 32'h1FF8);
        wr(`TSR_OFF_LOWER, 32'h0000);
        smp(13'h1FFE);
        rd(`TSR_OFF_TEMP, 32'hFFFE);
        irq_is(1'b0);
        wr(`TSR_OFF_MASK, 32'h4);
        rd(`TSR_OFF_MASK, 32'h4);
        irq_is(1'b1);
        rd(`TSR_OFF_STATUS, 32'h6);
        irq_is(1'b0);
        // reset in mid-run must drop programmed limits, mask and read-back
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
        irq_is(1'b0);
        complete_run();
    end
endmodule
